// ==== bbt_regs.sv ====
// Output target and status register bank behind a two-wire serial slave
//
// What this block does
// - Threshold codes 0x8C to 0xFF all give the saturated 70 mV limit.
// - Below saturation each threshold code step adds half a millivolt.
// - Target low byte at 0xC, read/write bits 7:0, resets to 0x58.
// - Target high bits 11:8 at 0xD bits 3:0, register resets to 0x02.
// - Both target bytes join into one 12-bit set point code.
// - Lowest target is 3.3 V or 1 V by divider select.
// - Highest target is 48 V or 24 V by the same select.
// - One code step is 20 mV wide range, 10 mV narrow range.
// - Writes to unimplemented bits are ignored.
// - Unimplemented bits always read zero.
// - Read-only status at 0x21, bit 6 is live constant-current state.
// - Read-only fault summary at 0x78, resets to 0x00.
// - Fault bits: busy, off, OV, OC, UV, temp, comm, other.
`timescale 1ns/1ps
`default_nettype none
module bbt_regs (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic feedback_divider_select,
    input wire logic current_limit_active,
    input wire logic [7:0] fault_flags,
    input wire logic [7:0] current_limit_threshold,
    output logic [bbt_pkg::VCODE_W-1:0] vout_target_code,
    output logic [bbt_pkg::SETPOINT_W-1:0] vout_setpoint_mv,
    output logic [7:0] ilim_sense_halfmv
);
    import bbt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Line edge and bus condition detection
    logic scl_q;
    logic sda_q;
    wire logic scl_rise;
    wire logic scl_fall;
    wire logic start_cond;
    wire logic stop_cond;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    assign scl_rise = scl & ~scl_q;
    assign scl_fall = ~scl & scl_q;
    // Data moving while the clock is high marks start or stop
    assign start_cond = scl & scl_q & sda_q & ~sda_in;
    assign stop_cond = scl & scl_q & ~sda_q & sda_in;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] vout_low;
    logic [VOUT_HIGH_W-1:0] vout_high;
    logic cc_status;
    logic [7:0] fault_summary;
    logic wr_en;
    logic [7:0] ptr;
    logic [7:0] sh;
    wire logic hit_low;
    wire logic hit_high;
    wire logic hit_cc;
    wire logic hit_fault;
    wire logic wr_low;
    wire logic wr_high;
    wire logic [7:0] high_byte;
    wire logic [7:0] cc_byte;
    wire logic [7:0] rd_byte;

    // Pointer decode shared by the write strobes and the read mux
    assign hit_low = ptr == OFS_VOUT_LOW;
    assign hit_high = ptr == OFS_VOUT_HIGH;
    assign hit_cc = ptr == OFS_CURRENT_LIMIT_STATE;
    assign hit_fault = ptr == OFS_FAULT_SUMMARY;
    // Only the two target bytes have a write path
    assign wr_low = wr_en && hit_low;
    assign wr_high = wr_en && hit_high;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            vout_low <= RST_VOUT_LOW;
        end else if (wr_low) begin
            vout_low <= sh;
        end
    end

    // Upper nibble of the written byte has nowhere to go
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            vout_high <= RST_VOUT_HIGH;
        end else if (wr_high) begin
            vout_high <= sh[VOUT_HIGH_W-1:0];
        end
    end

    // Status is resampled every cycle, so it never holds a stale event
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cc_status <= RST_STATUS_BIT;
        end else begin
            cc_status <= current_limit_active;
        end
    end

    // Fault bits pass straight through; their sources own any latching
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fault_summary <= RST_FAULT_SUMMARY;
        end else begin
            fault_summary <= fault_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back path
    // Status offsets have no write path at all
    // Unimplemented bits are tied to zero in the read images
    assign high_byte = {4'h0, vout_high};
    assign cc_byte = 8'(cc_status) << CC_BIT;
    assign rd_byte =
        hit_low ? vout_low :
        hit_high ? high_byte :
        hit_cc ? cc_byte :
        hit_fault ? fault_summary :
        8'h00;

    // Halves are used as they stand; the host pairs its two writes
    assign vout_target_code = {vout_high, vout_low};

    ////////////////////////////////////////////////////////////////////////
    // Serial slave state machine
    bbt_state_t state;
    bbt_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] next_sh;
    logic [7:0] next_ptr;
    logic rw;
    logic next_rw;
    logic nack;
    logic next_nack;
    wire logic byte_full;
    wire logic byte_end;
    wire logic addr_match;
    wire logic [7:0] shift_in;
    wire logic [7:0] shift_out;
    wire logic [7:0] ptr_inc;
    wire logic [3:0] cnt_inc;
    wire logic ack_phase;
    wire logic read_low;
    wire logic drive_low;

    assign byte_full = cnt == BITS_PER_BYTE;
    // Fall after the eighth sampled bit closes a byte
    assign byte_end = scl_fall && byte_full;
    assign addr_match = sh[7:1] == DEV_ADDR;
    // Data moves MSB first in both directions
    assign shift_in = {sh[6:0], sda_in};
    assign shift_out = {sh[6:0], 1'b0};
    // Pointer wraps from 0xFF back to zero
    assign ptr_inc = ptr + 8'h01;
    assign cnt_inc = cnt + 4'h1;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_ptr = ptr;
        next_rw = rw;
        next_nack = nack;
        wr_en = 1'b0;
        if (start_cond) begin
            next_state = ST_ADDR;
            next_cnt = 4'h0;
            // A new frame forgets the previous host acknowledge
            next_nack = 1'b0;
        end else if (stop_cond) begin
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_cnt = 4'h0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        next_sh = shift_in;
                        next_cnt = cnt_inc;
                    end else if (byte_end) begin
                        next_cnt = 4'h0;
                        if (state == ST_ADDR) begin
                            next_rw = sh[0];
                            next_state = addr_match ? ST_AACK : ST_IDLE;
                        end else if (state == ST_PTR) begin
                            next_ptr = sh;
                            next_state = ST_PACK;
                        end else begin
                            wr_en = 1'b1;
                            next_ptr = ptr_inc;
                            next_state = ST_WACK;
                        end
                    end
                end
                ST_AACK, ST_PACK, ST_WACK: begin
                    if (scl_fall) begin
                        if (state == ST_AACK && rw) begin
                            next_sh = rd_byte;
                            next_ptr = ptr_inc;
                            next_state = ST_RDATA;
                        end else if (state == ST_AACK) begin
                            next_state = ST_PTR;
                        end else begin
                            next_state = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        next_cnt = cnt_inc;
                    end else if (byte_end) begin
                        next_cnt = 4'h0;
                        next_state = ST_RACK;
                    end else if (scl_fall) begin
                        next_sh = shift_out;
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        next_nack = sda_in;
                    end else if (scl_fall && nack) begin
                        next_state = ST_IDLE;
                    end else if (scl_fall) begin
                        next_sh = rd_byte;
                        next_ptr = ptr_inc;
                        next_state = ST_RDATA;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
        end
    end

    // Pointer, direction and host acknowledge
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ptr <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
        end else begin
            ptr <= next_ptr;
            rw <= next_rw;
            nack <= next_nack;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain data pin: only ever pulled low, never driven high
    // Acknowledge slots for address, pointer and written data
    assign ack_phase = (state == ST_AACK) || (state == ST_PACK) ||
        (state == ST_WACK);
    // Read data: only zero bits pull the line down
    assign read_low = (state == ST_RDATA) && !sh[7];
    assign drive_low = ack_phase || read_low;
    assign sda_out = 1'b0;
    assign sda_oe_n = ~drive_low;

    ////////////////////////////////////////////////////////////////////////
    // Consumers of the stored settings
    bbt_ilim_decode u_ilim (
        .mclk(mclk),
        .rstn(rstn),
        .code(current_limit_threshold),
        .sense_halfmv(ilim_sense_halfmv)
    );

    bbt_vout_setpoint u_setpoint (
        .mclk(mclk),
        .rstn(rstn),
        .wide_range(feedback_divider_select),
        .code(vout_target_code),
        .setpoint_mv(vout_setpoint_mv)
    );

endmodule
`default_nettype wire

// ==== bbt_pkg.sv ====
// Constants and types shared by the converter target and status registers
package bbt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_VOUT_LOW = 8'h0c;
    localparam logic [7:0] OFS_VOUT_HIGH = 8'h0d;
    localparam logic [7:0] OFS_CURRENT_LIMIT_STATE = 8'h21;
    localparam logic [7:0] OFS_FAULT_SUMMARY = 8'h78;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and field layout
    localparam logic [7:0] RST_VOUT_LOW = 8'h58;
    localparam logic [3:0] RST_VOUT_HIGH = 4'h2;
    localparam logic RST_STATUS_BIT = 1'b0;
    localparam logic [7:0] RST_FAULT_SUMMARY = 8'h00;
    localparam int VOUT_HIGH_W = 4;
    localparam int VCODE_W = 12;
    localparam int CC_BIT = 6;

    // Fault summary bit positions
    localparam int FLT_BUSY = 7;
    localparam int FLT_OFF = 6;
    localparam int FLT_VOUT_OV = 5;
    localparam int FLT_IOUT_OC = 4;
    localparam int FLT_VIN_UV = 3;
    localparam int FLT_TEMP = 2;
    localparam int FLT_COMM_LOGIC_MEMORY = 1;
    localparam int FLT_OTHER = 0;

    ////////////////////////////////////////////////////////////////////////
    // Current limit threshold: one code step is 0.5 mV (50 mA)
    localparam logic [7:0] ILIM_SAT_CODE = 8'h8c;

    ////////////////////////////////////////////////////////////////////////
    // Output target ranges in millivolts
    localparam int SETPOINT_W = 17;
    localparam logic [16:0] WIDE_MIN_MV = 17'h00ce4;
    localparam logic [16:0] WIDE_MAX_MV = 17'h0bb80;
    localparam logic [4:0] WIDE_STEP_MV = 5'h14;
    localparam logic [16:0] NARROW_MIN_MV = 17'h003e8;
    localparam logic [16:0] NARROW_MAX_MV = 17'h05dc0;
    localparam logic [4:0] NARROW_STEP_MV = 5'h0a;

    ////////////////////////////////////////////////////////////////////////
    // Serial link
    localparam logic [6:0] DEV_ADDR = 7'h2a; // Arbitrary value
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_AACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK = 9'h100
    } bbt_state_t;

endpackage

// ==== bbt_ilim_decode.sv ====
// Current limit threshold code to sense threshold in half-millivolt units
`timescale 1ns/1ps
`default_nettype none
module bbt_ilim_decode (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] code,
    output logic [7:0] sense_halfmv
);
    import bbt_pkg::*;

    wire logic saturated;
    wire logic [7:0] next_sense;

    assign saturated = code >= ILIM_SAT_CODE;
    assign next_sense = saturated ? ILIM_SAT_CODE : code;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sense_halfmv <= 8'h00;
        end else begin
            sense_halfmv <= next_sense;
        end
    end

endmodule
`default_nettype wire

// ==== bbt_vout_setpoint.sv ====
// Output target code to set point in millivolts for either divider range
`timescale 1ns/1ps
`default_nettype none
module bbt_vout_setpoint (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic wide_range,
    input wire logic [bbt_pkg::VCODE_W-1:0] code,
    output logic [bbt_pkg::SETPOINT_W-1:0] setpoint_mv
);
    import bbt_pkg::*;

    wire logic [16:0] min_mv;
    wire logic [16:0] max_mv;
    wire logic [4:0] step_mv;
    wire logic [16:0] span_mv;
    wire logic [16:0] raw_mv;
    wire logic [16:0] next_setpoint;

    assign min_mv = wide_range ? WIDE_MIN_MV : NARROW_MIN_MV;
    assign max_mv = wide_range ? WIDE_MAX_MV : NARROW_MAX_MV;
    assign step_mv = wide_range ? WIDE_STEP_MV : NARROW_STEP_MV;
    // Widest product 4095 * 20 still fits in 17 bits
    assign span_mv = 17'(code) * 17'(step_mv);
    assign raw_mv = min_mv + span_mv;
    // Codes past the top of the range pin at the upper limit
    assign next_setpoint = (raw_mv > max_mv) ? max_mv : raw_mv;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            setpoint_mv <= 17'h00000;
        end else begin
            setpoint_mv <= next_setpoint;
        end
    end

endmodule
`default_nettype wire

// ==== bbt_regs_props.sv ====
// Port-level assertions for the target and status register bank
`timescale 1ns/1ps
`default_nettype none
module bbt_regs_props (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic feedback_divider_select,
    input wire logic current_limit_active,
    input wire logic [7:0] fault_flags,
    input wire logic [7:0] current_limit_threshold,
    input wire logic [bbt_pkg::VCODE_W-1:0] vout_target_code,
    input wire logic [bbt_pkg::SETPOINT_W-1:0] vout_setpoint_mv,
    input wire logic [7:0] ilim_sense_halfmv
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // Writes land after a low scl sample, never while scl stays high
    sequence s_bus_held;
        scl && $past(scl);
    endsequence
    sequence s_wide_lin;
        feedback_divider_select && vout_target_code <= 12'h8bb;
    endsequence
    sequence s_narrow_lin;
        !feedback_divider_select && vout_target_code <= 12'h8fc;
    endsequence

    rst_target_a: assert property ($rose(rstn) |->
        vout_target_code == 12'h258 && sda_oe_n) else $error("bad reset");
    sat_ilim_a: assert property (current_limit_threshold >= 8'hc1 |=>
        ilim_sense_halfmv == 8'h8c) else $error("no saturation");
    step_ilim_a: assert property (current_limit_threshold < 8'h8c |=>
        ilim_sense_halfmv == $past(current_limit_threshold))
        else $error("bad threshold step");
    target_idle_a: assert property (s_bus_held |->
        $stable(vout_target_code)) else $error("target moved");
    wide_step_a: assert property (s_wide_lin |=>
        vout_setpoint_mv == 17'd3300 + 17'($past(vout_target_code)) * 17'd20)
        else $error("bad wide set point");
    wide_clamp_a: assert property (feedback_divider_select &&
        vout_target_code >= 12'h8bc |=> vout_setpoint_mv == 17'd48000)
        else $error("bad wide clamp");
    narrow_step_a: assert property (s_narrow_lin |=>
        vout_setpoint_mv == 17'd1000 + 17'($past(vout_target_code)) * 17'd10)
        else $error("bad narrow set point");
    narrow_clamp_a: assert property (!feedback_divider_select &&
        vout_target_code >= 12'h8fd |=> vout_setpoint_mv == 17'd24000)
        else $error("bad narrow clamp");
endmodule

bind bbt_regs bbt_regs_props u_bbt_regs_props (
    .mclk(mclk), .rstn(rstn), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .feedback_divider_select(feedback_divider_select),
    .current_limit_active(current_limit_active),
    .fault_flags(fault_flags),
    .current_limit_threshold(current_limit_threshold),
    .vout_target_code(vout_target_code),
    .vout_setpoint_mv(vout_setpoint_mv),
    .ilim_sense_halfmv(ilim_sense_halfmv));
`default_nettype wire

// ==== bbt_host.sv ====
// Two-wire host model that drives the register link
`timescale 1ns/1ps
`default_nettype none
module bbt_host (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick();
        repeat (3) @(posedge mclk);
    endtask
    // Three mclk per phase, above the two-cycle minimum
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        tick();
        scl <= 1'b1;
        tick();
        r = sda;
        scl <= 1'b0;
        tick();
    endtask
    task automatic start();
        sda_low <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b0;
        tick();
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b0;
        tick();
    endtask
    task automatic wb(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic rb(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nack, r);
    endtask
endmodule
`default_nettype wire

// ==== test_bbt_regs.sv ====
// Self-checking bench for the converter target and status registers
`timescale 1ns/1ps
`default_nettype none
module test_bbt_regs;
    import bbt_pkg::*;
    logic mclk, rstn, feedback_divider_select, current_limit_active;
    logic [7:0] fault_flags, current_limit_threshold, ilim;
    logic [VCODE_W-1:0] code;
    logic [SETPOINT_W-1:0] setp;
    wire logic scl, sda_low, sda_out, sda_oe_n, sda;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    // Pull-up wins unless someone pulls low
    assign sda = (sda_oe_n | sda_out) & !sda_low;
    bbt_regs u_bbt_regs (
        .mclk(mclk), .rstn(rstn), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .feedback_divider_select(feedback_divider_select),
        .current_limit_active(current_limit_active),
        .fault_flags(fault_flags),
        .current_limit_threshold(current_limit_threshold),
        .vout_target_code(code), .vout_setpoint_mv(setp),
        .ilim_sense_halfmv(ilim));
    bbt_host u_bbt_host (.mclk(mclk), .sda(sda), .scl(scl),
        .sda_low(sda_low));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [16:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] p, d0, d1, input logic two);
        logic a;
        u_bbt_host.start();
        u_bbt_host.wb({DEV_ADDR, 1'b0}, a);
        chk("addr ack", a, 0);
        u_bbt_host.wb(p, a);
        chk("ptr ack", a, 0);
        u_bbt_host.wb(d0, a);
        chk("data ack", a, 0);
        if (two) begin
            u_bbt_host.wb(d1, a);
            chk("data ack", a, 0);
        end
        u_bbt_host.stop();
    endtask
    task automatic rc(input string what, input logic [7:0] p, exp);
        logic a;
        logic [7:0] d;
        u_bbt_host.start();
        u_bbt_host.wb({DEV_ADDR, 1'b0}, a);
        u_bbt_host.wb(p, a);
        u_bbt_host.start();
        u_bbt_host.wb({DEV_ADDR, 1'b1}, a);
        chk("read ack", a, 0);
        u_bbt_host.rb(1'b1, d);
        u_bbt_host.stop();
        chk(what, d, exp);
    endtask
    task automatic rseq(input logic [7:0] p, e0, e1);
        logic a;
        logic [7:0] d;
        u_bbt_host.start();
        u_bbt_host.wb({DEV_ADDR, 1'b0}, a);
        u_bbt_host.wb(p, a);
        u_bbt_host.start();
        u_bbt_host.wb({DEV_ADDR, 1'b1}, a);
        chk("seq ack", a, 0);
        u_bbt_host.rb(1'b0, d);
        chk("seq first", d, e0);
        u_bbt_host.rb(1'b1, d);
        chk("seq second", d, e1);
        u_bbt_host.stop();
    endtask
    task automatic sel(input logic s);
        feedback_divider_select <= s;
        repeat (2) @(posedge mclk);
    endtask
    task automatic t_reset();
        chk("code", code, 12'h258);
        chk("setpoint", setp, 17'd15300);
        rc("low", 8'h0c, 8'h58);
        rc("high", 8'h0d, 8'h02);
        rc("cc", 8'h21, 8'h00);
        rc("fault", 8'h78, 8'h00);
        $display("reset test end");
    endtask
    task automatic t_vout();
        wr(8'h0c, 8'h34, 8'hf5, 1'b1);
        rc("low", 8'h0c, 8'h34);
        rc("high", 8'h0d, 8'h05);
        chk("code", code, 12'h534);
        chk("wide", setp, 17'd29940);
        sel(1'b0);
        chk("narrow", setp, 17'd14320);
        wr(8'h0c, 8'h00, 8'h00, 1'b1);
        chk("narrow min", setp, 17'd1000);
        sel(1'b1);
        chk("wide min", setp, 17'd3300);
        wr(8'h0c, 8'hff, 8'hff, 1'b1);
        chk("wide max", setp, 17'd48000);
        sel(1'b0);
        chk("narrow max", setp, 17'd24000);
        sel(1'b1);
        rseq(8'h0c, 8'hff, 8'h0f);
        $display("target test end");
    endtask
    task automatic t_status();
        current_limit_active <= 1'b1;
        wr(8'h21, 8'hff, 8'h00, 1'b0);
        rc("cc on", 8'h21, 8'h40);
        current_limit_active <= 1'b0;
        rc("cc off", 8'h21, 8'h00);
        for (int i = 0; i < 8; i++) begin
            fault_flags <= 8'h01 << i;
            rc("fault bit", 8'h78, 8'h01 << i);
        end
        wr(8'h78, 8'h00, 8'h00, 1'b0);
        rc("fault ro", 8'h78, 8'h80);
        rc("unmapped", 8'h50, 8'h00);
        $display("status test end");
    endtask
    task automatic t_addr();
        logic a;
        u_bbt_host.start();
        u_bbt_host.wb({~DEV_ADDR, 1'b0}, a);
        chk("foreign ack", a, 1);
        u_bbt_host.wb(8'h0c, a);
        chk("ignored ack", a, 1);
        u_bbt_host.wb(8'h00, a);
        u_bbt_host.stop();
        rc("low kept", 8'h0c, 8'hff);
        $display("address test end");
    endtask
    task automatic t_ilim();
        logic [7:0] c[8] = '{8'h00, 8'h01, 8'h80, 8'h8b, 8'h8c, 8'hc0,
            8'hc1, 8'hff};
        for (int i = 0; i < 8; i++) begin
            current_limit_threshold <= c[i];
            repeat (3) @(posedge mclk);
            chk("ilim", ilim, c[i] > 8'h8c ? 8'h8c : c[i]);
        end
        $display("threshold test end");
    endtask
    initial begin
        rstn = 1'b0;
        feedback_divider_select = 1'b1;
        current_limit_active = 1'b0;
        fault_flags = 8'h00;
        current_limit_threshold = 8'h00;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_vout();
        t_addr();
        t_status();
        t_ilim();
        report_and_stop();
    end
endmodule
`default_nettype wire
